// ==== bench/sdc_mem_model.sv ====
`timescale 1ns/1ns
module sdc_mem_model
  import sdc_pkg::*;
(
  // Clock and command pins
  input  wire logic                  clk,
  input  wire sdc_pkg::sdc_cmd_t     mem_cmd,
  input  wire logic                  mem_cke,
  // Data lines
  input  wire logic [SDC_DATA_W-1:0] data_lines_o,
  input  wire logic                  data_lines_oe_n,
  output logic [SDC_DATA_W-1:0]      data_lines_i
);
  logic [31:0] mem [logic [20:0]];
  logic [10:0] mode_reg = SDC_MR_RESET;
  logic [3:0]  open_bank = 4'h0;
  logic [10:0] open_row [4] = '{default: 11'h0};
  int          ref_cnt = 0;
  int          err_cnt = 0;
  logic [11:0] pv = 12'h000;
  logic [31:0] pd [12];
  logic [31:0] last_q = 32'h0;
  logic [31:0] wv;
  logic [31:0] mk;
  logic [7:0]  c;
  logic [7:0]  m;
  logic [1:0]  b;
  int          bl;
  int          cl;

  function automatic logic [31:0] rd_word(input logic [20:0] k);
    return mem.exists(k) ? mem[k] : 32'h0;
  endfunction

  // Bursts beyond eight beats are cut to eight
  assign bl = (mode_reg[2:0] > 3'h3) ? 8 : (1 << mode_reg[2:0]);
  assign cl = int'(mode_reg[6:4]);
  // Idle lines show the inverse of the last word
  assign data_lines_i = pv[0] ? pd[0] : ~last_q;

  always @(posedge clk)
  begin
    for (int i = 0; i < 11; i++)
    begin
      pv[i] <= pv[i+1];
      pd[i] <= pd[i+1];
    end
    pv[11] <= 1'b0;
    if (pv[0])
      last_q <= pd[0];
    b = mem_cmd.bank_select;
    if (mem_cke && !mem_cmd.cs_n)
      case ({mem_cmd.ras_n, mem_cmd.cas_n, mem_cmd.we_n})
        SDC_CMD_ACT:
        begin
          open_bank[b] <= 1'b1;
          open_row[b] <= mem_cmd.address_bus;
        end
        SDC_CMD_WRITE:
        begin
          if (!open_bank[b] || data_lines_oe_n) err_cnt++;
          wv = rd_word({b, open_row[b], mem_cmd.address_bus[7:0]});
          for (int l = 0; l < 4; l++)
            if (!mem_cmd.byte_mask[l]) wv[8*l +: 8] = data_lines_o[8*l +: 8];
          mem[{b, open_row[b], mem_cmd.address_bus[7:0]}] = wv;
          if (mem_cmd.address_bus[SDC_AP_BIT]) open_bank[b] <= 1'b0;
        end
        SDC_CMD_READ:
        begin
          if (!open_bank[b]) err_cnt++;
          m = 8'(bl - 1);
          for (int l = 0; l < 4; l++)
            mk[8*l +: 8] = {8{mem_cmd.byte_mask[l]}};
          for (int i = 0; i < bl; i++)
          begin
            c = mem_cmd.address_bus[7:0];
            c = mode_reg[3] ? (c ^ 8'(i)) : ((c & ~m) | ((c + 8'(i)) & m));
            // Word i stands on the lines to be sampled cl+i edges after the command
            pv[cl-1+i] <= 1'b1;
            pd[cl-1+i] <= rd_word({b, open_row[b], c}) ^ mk;
          end
          if (mem_cmd.address_bus[SDC_AP_BIT]) open_bank[b] <= 1'b0;
        end
        SDC_CMD_PRE:
        begin
          if (mem_cmd.address_bus[SDC_AP_BIT]) open_bank <= 4'h0;
          else open_bank[b] <= 1'b0;
          for (int i = cl - 1; i < 12; i++) pv[i] <= 1'b0;
        end
        SDC_CMD_BST: for (int i = cl - 1; i < 12; i++) pv[i] <= 1'b0;
        SDC_CMD_REF:
        begin
          ref_cnt++;
          if (open_bank != 4'h0) err_cnt++;
        end
        SDC_CMD_MRS: mode_reg <= mem_cmd.address_bus;
        default: ;
      endcase
  end
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/1ns
module testbench;
  import sdc_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        ce = 1'b1;
  logic [5:0]  s_awaddr = 6'h00, s_araddr = 6'h00;
  logic [31:0] s_wdata = 32'h0;
  logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, mem_cke, data_lines_oe_n;
  logic [1:0]  s_bresp, s_rresp;
  logic [31:0] s_rdata, data_lines_o, data_lines_i, rv;
  sdc_cmd_t    mem_cmd;
  int          err_total = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          n0;

  sdc_ctrl #(.REF_STD_CYC(20), .REF_EXT_CYC(10)) DUT
  (
    .clk, .reset, .ce,
    .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb(4'hf), .s_wvalid, .s_wready,
    .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
    .s_rvalid, .s_rready, .mem_cmd, .mem_cke, .data_lines_o, .data_lines_oe_n, .data_lines_i
  );
  sdc_mem_model mdl (.clk, .mem_cmd, .mem_cke, .data_lines_o, .data_lines_oe_n, .data_lines_i);

  always #2 clk = ~clk;

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge clk);
      if (s_awready === 1'b1 && !aw_done)
      begin
        s_awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (s_wready === 1'b1 && !w_done)
      begin
        s_wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    s_bready <= 1'b1;
    do @(posedge clk); while (s_bvalid !== 1'b1);
    chk(s_bresp, er);
    s_bready <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d, input logic [1:0] er);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do @(posedge clk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    s_rready <= 1'b1;
    do @(posedge clk); while (s_rvalid !== 1'b1);
    d = s_rdata;
    chk(s_rresp, er);
    s_rready <= 1'b0;
  endtask

  // Issue one memory command and wait for busy to clear
  task automatic cmd(input logic [2:0] code, input logic [3:0] m, input logic ds, input logic [31:0] a);
    int n;
    wr(SDC_OFS_ADDR, a, SDC_RESP_OKAY);
    wr(SDC_OFS_CMD, {23'h0, ds, m, 1'b0, code}, SDC_RESP_OKAY);
    n = 0;
    do
    begin
      rd(SDC_OFS_STAT, rv, SDC_RESP_OKAY);
      n++;
    end
    while (rv[0] !== 1'b0 && n < 50);
  endtask

  task automatic rd_chk(input logic [31:0] exp);
    rd(SDC_OFS_STAT, rv, SDC_RESP_OKAY);
    chk(rv[1], 1'b1);
    rd(SDC_OFS_RDATA, rv, SDC_RESP_OKAY);
    chk(rv, exp);
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    chk(mem_cmd.cs_n, 1'b1);
    chk(data_lines_oe_n, 1'b1);
    chk(mem_cke, 1'b0);
    reset <= 1'b0;
    @(posedge clk);
    wr(SDC_OFS_CTRL, 32'h1, SDC_RESP_OKAY);
    repeat (2) @(posedge clk);
    chk(mem_cke, 1'b1);
    cmd(SDC_CMD_MRS, 4'h0, 1'b0, 32'h020);
    chk(mdl.mode_reg, 11'h020);
    $display("test mode load done");
    cmd(SDC_CMD_ACT, 4'h0, 1'b0, 32'h105a5);
    chk(mdl.open_bank, 4'h2);
    chk(mdl.open_row[1], 11'h5a5);
    wr(SDC_OFS_WDATA, 32'h12345678, SDC_RESP_OKAY);
    cmd(SDC_CMD_WRITE, 4'h0, 1'b0, 32'h10033);
    wr(SDC_OFS_WDATA, 32'hffffffff, SDC_RESP_OKAY);
    cmd(SDC_CMD_WRITE, 4'he, 1'b0, 32'h10033);
    chk(mdl.mem[21'h0da533], 32'h123456ff);
    for (int g = 0; g < 2; g++)
    begin
      wr(SDC_OFS_CTRL, 32'h1 | (g << 3), SDC_RESP_OKAY);
      cmd(SDC_CMD_MRS, 4'h0, 1'b0, 32'h020 + (g << 4));
      cmd(SDC_CMD_READ, 4'h0, 1'b0, 32'h10033);
      rd_chk(32'h123456ff);
    end
    cmd(SDC_CMD_READ, 4'h0, 1'b0, 32'h10433);
    rd_chk(32'h123456ff);
    chk(mdl.open_bank, 4'h0);
    $display("test write read done");
    cmd(SDC_CMD_ACT, 4'h0, 1'b0, 32'h20003);
    cmd(SDC_CMD_ACT, 4'h0, 1'b0, 32'h105a5);
    cmd(SDC_CMD_PRE, 4'h0, 1'b0, 32'h20000);
    chk(mdl.open_bank, 4'h2);
    cmd(SDC_CMD_READ, 4'h0, 1'b0, 32'h10033);
    rd_chk(32'h123456ff);
    cmd(SDC_CMD_PRE, 4'h0, 1'b0, 32'h00400);
    chk(mdl.open_bank, 4'h0);
    $display("test banks done");
    cmd(SDC_CMD_ACT, 4'h0, 1'b1, 32'h105a5);
    chk(mdl.open_bank, 4'h0);
    wr(SDC_OFS_CTRL, 32'h0, SDC_RESP_OKAY);
    cmd(SDC_CMD_ACT, 4'h0, 1'b0, 32'h105a5);
    chk(mdl.open_bank, 4'h0);
    chk(mem_cke, 1'b0);
    wr(SDC_OFS_CTRL, 32'h1, SDC_RESP_OKAY);
    cmd(SDC_CMD_PRE, 4'h0, 1'b0, 32'h00400);
    wr(6'h18, 32'h0, SDC_RESP_SLVERR);
    rd(6'h18, rv, SDC_RESP_SLVERR);
    $display("test select and errors done");
    // Enable low: a pending read request must not be taken
    ce <= 1'b0;
    s_araddr <= SDC_OFS_STAT;
    s_arvalid <= 1'b1;
    repeat (10) @(posedge clk);
    chk(s_arready, 1'b0);
    chk(mem_cke, 1'b1);
    ce <= 1'b1;
    rd(SDC_OFS_STAT, rv, SDC_RESP_OKAY);
    chk(rv[0], 1'b0);
    $display("test enable freeze done");
    for (int g = 0; g < 2; g++)
    begin
      n0 = mdl.ref_cnt;
      wr(SDC_OFS_CTRL, 32'h3 | (g << 2), SDC_RESP_OKAY);
      repeat (200) @(posedge clk);
      wr(SDC_OFS_CTRL, 32'h1, SDC_RESP_OKAY);
      repeat (20) @(posedge clk);
      chk(mdl.ref_cnt - n0 >= (g ? 19 : 9), 1'b1);
    end
    rd(SDC_OFS_STAT, rv, SDC_RESP_OKAY);
    chk(rv[31:16], mdl.ref_cnt[15:0]);
    chk(mdl.err_cnt, 32'h0);
    $display("test refresh done");
    end_sim();
  end
endmodule

// ==== hw/sdc_ctrl.sv ====
`timescale 1ns/1ns
module sdc_ctrl
  import sdc_pkg::*;
#(
  parameter int REF_STD_CYC = SDC_REF_STD_CYC,
  parameter int REF_EXT_CYC = SDC_REF_EXT_CYC
)
(
  // Clock, reset, enable
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  ce,
  // AXI4-Lite write
  input  wire logic [5:0]            s_awaddr,
  input  wire logic                  s_awvalid,
  output logic                       s_awready,
  input  wire logic [31:0]           s_wdata,
  input  wire logic [3:0]            s_wstrb,
  input  wire logic                  s_wvalid,
  output logic                       s_wready,
  output logic [1:0]                 s_bresp,
  output logic                       s_bvalid,
  input  wire logic                  s_bready,
  // AXI4-Lite read
  input  wire logic [5:0]            s_araddr,
  input  wire logic                  s_arvalid,
  output logic                       s_arready,
  output logic [31:0]                s_rdata,
  output logic [1:0]                 s_rresp,
  output logic                       s_rvalid,
  input  wire logic                  s_rready,
  // Memory pins
  output sdc_pkg::sdc_cmd_t          mem_cmd,
  output logic                       mem_cke,
  output logic [SDC_DATA_W-1:0]      data_lines_o,
  output logic                       data_lines_oe_n,
  input  wire logic [SDC_DATA_W-1:0] data_lines_i
);
  import sdc_pkg::*;

  localparam sdc_cmd_t CMD_IDLE = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                                    bank_select: '0, address_bus: '0, byte_mask: '1};

  // Register state
  sdc_cmd_t             cmd_reg,   cmd_next;
  logic                 cke_reg,   cke_next;
  logic [31:0]          wd_reg,    wd_next;
  logic                 oe_n_reg,  oe_n_next;
  logic [31:0]          rd_reg,    rd_next;
  logic [31:0]          addr_reg,  addr_next;
  logic [3:0]           ctrl_reg,  ctrl_next;
  logic [8:0]           op_reg,    op_next;
  logic                 busy_reg,  busy_next;
  logic                 rdv_reg,   rdv_next;
  sdc_state_t           st_reg,    st_next;
  logic [2:0]           lat_reg,   lat_next;
  logic [31:0]          refc_reg,  refc_next;
  logic                 refp_reg,  refp_next;
  logic [15:0]          refn_reg,  refn_next;
  logic                 aw_reg,    aw_next;
  logic                 w_reg,     w_next;
  logic [5:0]           awa_reg,   awa_next;
  logic [31:0]          wdh_reg,   wdh_next;
  logic                 bv_reg,    bv_next;
  logic [1:0]           br_reg,    br_next;
  logic                 arr_reg,   arr_next;
  logic                 rv_reg,    rv_next;
  logic [31:0]          rdt_reg,   rdt_next;
  logic [1:0]           rr_reg,    rr_next;
  logic [SDC_DATA_W-1:0] dq_s1_reg, dq_s2_reg;

  logic       issue;
  logic [2:0] issue_code;
  logic [2:0] lat_cfg;
  logic [31:0] ref_lim;

  assign lat_cfg = ctrl_reg[SDC_CTF_CL3_BIT] ? SDC_CL3 : SDC_CL2;
  assign ref_lim = ctrl_reg[SDC_CTF_EXT_BIT] ? REF_EXT_CYC : REF_STD_CYC;

  always_comb
  begin
    aw_next   = aw_reg;
    w_next    = w_reg;
    awa_next  = awa_reg;
    wdh_next  = wdh_reg;
    bv_next   = bv_reg;
    br_next   = br_reg;
    arr_next  = arr_reg;
    rv_next   = rv_reg;
    rdt_next  = rdt_reg;
    rr_next   = rr_reg;
    addr_next = addr_reg;
    ctrl_next = ctrl_reg;
    wd_next   = wd_reg;
    op_next   = op_reg;
    issue     = 1'b0;
    issue_code = SDC_CMD_NOP;
    if (s_awvalid && !aw_reg && !bv_reg)
    begin
      aw_next  = 1'b1;
      awa_next = s_awaddr;
    end
    if (s_wvalid && !w_reg && !bv_reg)
    begin
      w_next   = 1'b1;
      wdh_next = s_wdata;
    end
    if (aw_reg && w_reg && !bv_reg)
    begin
      aw_next = 1'b0;
      w_next  = 1'b0;
      bv_next = 1'b1;
      br_next = SDC_RESP_OKAY;
      case (awa_reg)
        SDC_OFS_CMD:
        begin
          if (busy_reg || st_reg != SDC_IDLE)
            br_next = SDC_RESP_SLVERR;
          else
          begin
            issue      = 1'b1;
            issue_code = wdh_reg[SDC_CMDF_CODE_LSB +: 3];
            op_next    = wdh_reg[SDC_CMDF_CODE_LSB +: 9];
          end
        end
        SDC_OFS_ADDR:  addr_next = wdh_reg;
        SDC_OFS_WDATA: wd_next   = wdh_reg;
        SDC_OFS_CTRL:  ctrl_next = wdh_reg[3:0];
        default:       br_next   = SDC_RESP_SLVERR;
      endcase
    end
    if (bv_reg && s_bready)
      bv_next = 1'b0;
    arr_next = 1'b0;
    if (s_arvalid && !rv_reg && !arr_reg)
      arr_next = 1'b1;
    // Answer only after the address handshake
    if (s_arvalid && arr_reg)
    begin
      rv_next  = 1'b1;
      rr_next  = SDC_RESP_OKAY;
      case (s_araddr)
        SDC_OFS_CMD:   rdt_next = {23'h0, op_reg};
        SDC_OFS_ADDR:  rdt_next = addr_reg;
        SDC_OFS_WDATA: rdt_next = wd_reg;
        SDC_OFS_RDATA: rdt_next = rd_reg;
        SDC_OFS_STAT:  rdt_next = {refn_reg, 13'h0, refp_reg, rdv_reg, busy_reg};
        SDC_OFS_CTRL:  rdt_next = {28'h0, ctrl_reg};
        default:
        begin
          rdt_next = 32'h0;
          rr_next  = SDC_RESP_SLVERR;
        end
      endcase
    end
    if (rv_reg && s_rready)
      rv_next = 1'b0;
  end

  // Pin sequencing
  always_comb
  begin
    cmd_next  = CMD_IDLE;
    cke_next  = ctrl_reg[SDC_CTF_CKE_BIT];
    oe_n_next = 1'b1;
    busy_next = busy_reg;
    rdv_next  = rdv_reg;
    rd_next   = rd_reg;
    st_next   = st_reg;
    lat_next  = lat_reg;
    refc_next = refc_reg;
    refp_next = refp_reg;
    refn_next = refn_reg;
    if (issue && cke_reg)
    begin
      cmd_next.cs_n = 1'b0;
      {cmd_next.ras_n, cmd_next.cas_n, cmd_next.we_n} = issue_code;
      cmd_next.byte_mask = wdh_reg[SDC_CMDF_MASK_LSB +: SDC_MASK_W];
      cmd_next.bank_select = addr_reg[SDC_ADF_BANK_LSB +: SDC_BANK_W];
      cmd_next.address_bus = addr_reg[SDC_ROW_W-1:0];
      if (wdh_reg[SDC_CMDF_CS_BIT])
        cmd_next.cs_n = 1'b1;
      if (issue_code == SDC_CMD_WRITE)
        oe_n_next = 1'b0;
      if (issue_code == SDC_CMD_READ && !wdh_reg[SDC_CMDF_CS_BIT])
      begin
        busy_next = 1'b1;
        rdv_next  = 1'b0;
        lat_next  = lat_cfg + SDC_RD_PIPE;
        st_next   = SDC_WAIT_RD;
      end
      if (issue_code == SDC_CMD_REF)
        refp_next = 1'b0;
    end
    else if (st_reg == SDC_IDLE && refp_reg && ctrl_reg[SDC_CTF_REFEN_BIT] && cke_reg)
    begin
      cmd_next.cs_n = 1'b0;
      {cmd_next.ras_n, cmd_next.cas_n, cmd_next.we_n} = SDC_CMD_REF;
      refp_next = 1'b0;
      refn_next = refn_reg + 16'h1;
    end
    // Counted last so a new interval beats a clear in the same cycle
    if (ctrl_reg[SDC_CTF_REFEN_BIT])
    begin
      if (refc_reg >= ref_lim - 1)
      begin
        refc_next = 32'h0;
        refp_next = 1'b1;
      end
      else
        refc_next = refc_reg + 32'h1;
    end
    case (st_reg)
      SDC_IDLE:    ;
      SDC_WAIT_RD:
      begin
        if (cke_reg)
        begin
          // Data leaves the two-flop sampler two edges late
          if (lat_reg == 3'h0)
          begin
            rd_next   = dq_s2_reg;
            rdv_next  = 1'b1;
            busy_next = 1'b0;
            st_next   = SDC_IDLE;
          end
          else
            lat_next = lat_reg - 3'h1;
        end
      end
      default: st_next = SDC_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cmd_reg   <= CMD_IDLE;
      cke_reg   <= 1'b0;
      wd_reg    <= 32'h0;
      oe_n_reg  <= 1'b1;
      rd_reg    <= 32'h0;
      addr_reg  <= 32'h0;
      ctrl_reg  <= 4'h0;
      op_reg    <= 9'h0;
      busy_reg  <= 1'b0;
      rdv_reg   <= 1'b0;
      st_reg    <= SDC_IDLE;
      lat_reg   <= 3'h0;
      refc_reg  <= 32'h0;
      refp_reg  <= 1'b0;
      refn_reg  <= 16'h0;
      aw_reg    <= 1'b0;
      w_reg     <= 1'b0;
      awa_reg   <= 6'h0;
      wdh_reg   <= 32'h0;
      bv_reg    <= 1'b0;
      br_reg    <= 2'h0;
      arr_reg   <= 1'b0;
      rv_reg    <= 1'b0;
      rdt_reg   <= 32'h0;
      rr_reg    <= 2'h0;
      dq_s1_reg <= '0;
      dq_s2_reg <= '0;
    end
    else if (ce)
    begin
      cmd_reg   <= cmd_next;
      cke_reg   <= cke_next;
      wd_reg    <= wd_next;
      oe_n_reg  <= oe_n_next;
      rd_reg    <= rd_next;
      addr_reg  <= addr_next;
      ctrl_reg  <= ctrl_next;
      op_reg    <= op_next;
      busy_reg  <= busy_next;
      rdv_reg   <= rdv_next;
      st_reg    <= st_next;
      lat_reg   <= lat_next;
      refc_reg  <= refc_next;
      refp_reg  <= refp_next;
      refn_reg  <= refn_next;
      aw_reg    <= aw_next;
      w_reg     <= w_next;
      awa_reg   <= awa_next;
      wdh_reg   <= wdh_next;
      bv_reg    <= bv_next;
      br_reg    <= br_next;
      arr_reg   <= arr_next;
      rv_reg    <= rv_next;
      rdt_reg   <= rdt_next;
      rr_reg    <= rr_next;
      dq_s1_reg <= data_lines_i;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  assign mem_cmd         = cmd_reg;
  assign mem_cke         = cke_reg;
  assign data_lines_o    = wd_reg;
  assign data_lines_oe_n = oe_n_reg;
  assign s_awready       = aw_reg;
  assign s_wready        = w_reg;
  assign s_bvalid        = bv_reg;
  assign s_bresp         = br_reg;
  assign s_arready       = arr_reg;
  assign s_rvalid        = rv_reg;
  assign s_rdata         = rdt_reg;
  assign s_rresp         = rr_reg;

  AST_IDLE_DESELECT: assert property (@(posedge clk) disable iff (reset)
    (ce && !issue && !(st_reg == SDC_IDLE && refp_reg && ctrl_reg[SDC_CTF_REFEN_BIT] && cke_reg))
    |=> mem_cmd.cs_n || $past(!ce))
    else $error("chip select asserted without a command");
  AST_WRITE_DRIVE: assert property (@(posedge clk) disable iff (reset)
    (!data_lines_oe_n) |-> ({mem_cmd.ras_n, mem_cmd.cas_n, mem_cmd.we_n} == SDC_CMD_WRITE))
    else $error("data driven outside a write");
  AST_READ_LAT: assert property (@(posedge clk) disable iff (reset)
    (ce && issue && issue_code == SDC_CMD_READ && !wdh_reg[SDC_CMDF_CS_BIT] && cke_reg)
    |=> busy_reg && !rdv_reg)
    else $error("read not tracked");
  AST_REF_CLEAR: assert property (@(posedge clk) disable iff (reset)
    (mem_cmd.cs_n == 1'b0 && {mem_cmd.ras_n, mem_cmd.cas_n, mem_cmd.we_n} == SDC_CMD_REF
     && $past(refp_reg) && $past(ce)) |-> !refp_reg || $past(refc_reg) >= $past(ref_lim) - 1)
    else $error("refresh request not cleared");
  AST_BRESP_HOLD: assert property (@(posedge clk) disable iff (reset)
    (s_bvalid && !s_bready) |=> s_bvalid || $past(!ce))
    else $error("write response dropped");
  AST_CMD_BANK: assert property (@(posedge clk) disable iff (reset)
    ($past(ce) && $past(issue) && $past(cke_reg) && !mem_cmd.cs_n)
    |-> mem_cmd.bank_select == $past(addr_reg[SDC_ADF_BANK_LSB +: SDC_BANK_W]))
    else $error("bank select mismatch");
  AST_CMD_CODE: assert property (@(posedge clk) disable iff (reset)
    ($past(ce) && $past(issue) && $past(cke_reg) && !mem_cmd.cs_n)
    |-> {mem_cmd.ras_n, mem_cmd.cas_n, mem_cmd.we_n} == $past(issue_code))
    else $error("command strobes mismatch");
  AST_ROW_ADDR: assert property (@(posedge clk) disable iff (reset)
    ($past(ce) && $past(issue) && $past(cke_reg) && !mem_cmd.cs_n)
    |-> mem_cmd.address_bus == $past(addr_reg[SDC_ROW_W-1:0]))
    else $error("address mismatch");
endmodule

// ==== hw/sdc_pkg.sv ====
package sdc_pkg;
  // Geometry
  localparam int SDC_ROW_W  = 11;
  localparam int SDC_COL_W  = 8;
  localparam int SDC_BANK_W = 2;
  localparam int SDC_DATA_W = 32;
  localparam int SDC_MASK_W = 4;
  localparam int SDC_ROWS   = 2048;
  localparam int SDC_COLS   = 256;
  localparam int SDC_AP_BIT = 10;

  // Command codes {row strobe, column strobe, write strobe}, active low
  localparam logic [2:0] SDC_CMD_NOP   = 3'h7;
  localparam logic [2:0] SDC_CMD_ACT   = 3'h3;
  localparam logic [2:0] SDC_CMD_READ  = 3'h5;
  localparam logic [2:0] SDC_CMD_WRITE = 3'h4;
  localparam logic [2:0] SDC_CMD_BST   = 3'h6;
  localparam logic [2:0] SDC_CMD_PRE   = 3'h2;
  localparam logic [2:0] SDC_CMD_REF   = 3'h1;
  localparam logic [2:0] SDC_CMD_MRS   = 3'h0;

  // Mode word fields
  localparam int SDC_MR_BL_LSB  = 0;
  localparam int SDC_MR_BT_BIT  = 3;
  localparam int SDC_MR_CL_LSB  = 4;
  localparam int SDC_MR_WB_BIT  = 9;
  localparam logic [10:0] SDC_MR_RESET = 11'h022;

  // Read latency codes; two sampler flops sit ahead of the capture
  localparam logic [2:0] SDC_CL2     = 3'h2;
  localparam logic [2:0] SDC_CL3     = 3'h3;
  localparam logic [2:0] SDC_RD_PIPE = 3'h2;

  // Refresh: 4096 rows in 64 ms (standard) or 16 ms (extended)
  localparam int SDC_REF_ROWS     = 4096;
  localparam int SDC_REF_STD_MS   = 64;
  localparam int SDC_REF_EXT_MS   = 16;
  localparam int SDC_CLK_KHZ      = 250000;
  localparam int SDC_REF_STD_CYC  = (SDC_REF_STD_MS * SDC_CLK_KHZ) / SDC_REF_ROWS;
  localparam int SDC_REF_EXT_CYC  = (SDC_REF_EXT_MS * SDC_CLK_KHZ) / SDC_REF_ROWS;

  // Controller register byte offsets
  localparam logic [5:0] SDC_OFS_CMD   = 6'h00;
  localparam logic [5:0] SDC_OFS_ADDR  = 6'h04;
  localparam logic [5:0] SDC_OFS_WDATA = 6'h08;
  localparam logic [5:0] SDC_OFS_RDATA = 6'h0c;
  localparam logic [5:0] SDC_OFS_STAT  = 6'h10;
  localparam logic [5:0] SDC_OFS_CTRL  = 6'h14;

  // CMD register fields
  localparam int SDC_CMDF_CODE_LSB = 0;
  localparam int SDC_CMDF_MASK_LSB = 4;
  localparam int SDC_CMDF_CS_BIT   = 8;
  // ADDR register fields
  localparam int SDC_ADF_BANK_LSB  = 16;
  // CTRL register fields
  localparam int SDC_CTF_CKE_BIT   = 0;
  localparam int SDC_CTF_REFEN_BIT = 1;
  localparam int SDC_CTF_EXT_BIT   = 2;
  localparam int SDC_CTF_CL3_BIT   = 3;

  localparam logic [1:0] SDC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SDC_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic                  cs_n;
    logic                  ras_n;
    logic                  cas_n;
    logic                  we_n;
    logic [SDC_BANK_W-1:0] bank_select;
    logic [SDC_ROW_W-1:0]  address_bus;
    logic [SDC_MASK_W-1:0] byte_mask;
  } sdc_cmd_t;

  typedef enum logic [1:0] {SDC_IDLE, SDC_REFRESH, SDC_WAIT_RD} sdc_state_t;
endpackage
